// [rtl/bls_pkg.sv]
/*
 * package of the boot loader sequencer (host side): register map of the
 * controller, field positions, boot stream codes and timing counts.
 * assumes a single 10 MHz clock shared by every module that imports it.
 */
package bls_pkg;
	// ********************
	// register port
	// ********************
	localparam int          ADDR_W        = 4;
	localparam int          DATA_W        = 32;
	localparam logic [3:0]  REG_CTRL      = 4'h0;
	localparam logic [3:0]  REG_STATUS    = 4'h1;
	localparam logic [3:0]  REG_IMG_ADDR  = 4'h2;
	localparam logic [3:0]  REG_IMG_DATA  = 4'h3;
	localparam logic [3:0]  REG_IMG_LEN   = 4'h4;
	localparam logic [3:0]  REG_WAITS     = 4'h5;
	localparam logic [3:0]  REG_BASE      = 4'h6;
	localparam int          CTRL_START    = 0;
	localparam int          CTRL_MODE_LSB = 1;
	localparam int          CTRL_BASE_LSB = 3;
	localparam int          CTRL_FINISH   = 5;
	localparam logic [1:0]  MODE_SERIAL   = 2'h0;
	localparam logic [1:0]  MODE_HSHAKE   = 2'h1;
	localparam logic [1:0]  MODE_MEMORY   = 2'h2;
	localparam logic [1:0]  BASE_A        = 2'h0;
	localparam logic [1:0]  BASE_B        = 2'h1;
	localparam logic [1:0]  BASE_C        = 2'h2;

	// ********************
	// boot stream codes
	// ********************
	localparam logic [23:0] BOOT_ADDR_A   = 24'h001000;
	localparam logic [23:0] BOOT_ADDR_B   = 24'h810000;
	localparam logic [23:0] BOOT_ADDR_C   = 24'h900000;
	localparam logic [23:0] MIN_LOAD_ADDR = 24'h001000;
	localparam logic [31:0] WIDTH_8       = 32'h00000008;
	localparam logic [31:0] WIDTH_16      = 32'h00000010;
	localparam logic [31:0] WIDTH_32      = 32'h00000020;
	localparam logic [3:0]  STRB_IO       = 4'h0;
	localparam logic [3:0]  STRB_PRI      = 4'h4;
	localparam logic [3:0]  STRB_SEC      = 4'h8;
	localparam logic [2:0]  HDR_WORDS_MEM = 3'h4;
	localparam logic [2:0]  HDR_WORDS_SER = 3'h3;
	localparam int          IMG_AW        = 8;
	localparam int          IMG_DEPTH     = 256;
	localparam int          SER_BITS      = 32;

	// ********************
	// timing
	// ********************
	localparam int CLK_PERIOD_NS = 100;
	localparam int DEV_RESET_NS  = 1000;
	localparam int SEL_SETUP_NS  = 500;
	localparam logic [7:0] DEV_RESET_CYC = 8'((DEV_RESET_NS + CLK_PERIOD_NS
		- 1) / CLK_PERIOD_NS);
	localparam logic [7:0] SEL_SETUP_CYC = 8'((SEL_SETUP_NS + CLK_PERIOD_NS
		- 1) / CLK_PERIOD_NS);
	localparam logic [3:0] SER_HALF_CYC  = 4'h2;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
		logic              wr;
		logic              rd;
	} bls_req_type;
endpackage

// [rtl/bls_serial_tx.sv]
/*
 * serial boot word sender: makes bit clock and frame sync itself and
 * shifts one 32-bit word msb first per start pulse.
 * assumes the device samples data on the rising edge of the bit clock.
 */
`timescale 1ns/1ps
module bls_serial_tx
	import bls_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        reset_n,
	input  wire logic        start,
	input  wire logic [31:0] word,
	output logic             serial_clk,
	output logic             receive_frame_sync,
	output logic             serial_data,
	output logic             done
);
	logic [31:0] shreg, next_shreg;
	logic [5:0]  bits, next_bits;
	logic [3:0]  div, next_div;
	logic        busy, next_busy;
	logic        next_sclk, next_fs, next_sd, next_done;

	// ********************
	// shifter
	// ********************
	always_comb begin
		next_shreg = shreg;
		next_bits  = bits;
		next_div   = div;
		next_busy  = busy;
		next_sclk  = serial_clk;
		next_fs    = receive_frame_sync;
		next_sd    = serial_data;
		next_done  = 1'b0;
		if (!busy && start) begin
			next_busy  = 1'b1;
			next_shreg = {word[30:0], 1'b0};
			next_sd    = word[31];
			next_fs    = 1'b1;
			next_bits  = 6'(SER_BITS);
			next_div   = SER_HALF_CYC;
			next_sclk  = 1'b0;
		end else if (busy) begin
			if (div == 4'h1) begin
				next_div  = SER_HALF_CYC;
				next_sclk = ~serial_clk;
				if (serial_clk) begin
					next_fs   = 1'b0;
					next_bits = bits - 6'h1;
					next_sd   = shreg[31];
					next_shreg = {shreg[30:0], 1'b0};
					if (bits == 6'h1) begin
						next_busy = 1'b0;
						next_sclk = 1'b0;
						next_sd   = 1'b0;
						next_done = 1'b1;
					end
				end
			end else begin
				next_div = div - 4'h1;
			end
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			shreg              <= 32'h00000000;
			bits               <= 6'h00;
			div                <= 4'h0;
			busy               <= 1'b0;
			serial_clk         <= 1'b0;
			receive_frame_sync <= 1'b0;
			serial_data        <= 1'b0;
			done               <= 1'b0;
		end else begin
			shreg              <= next_shreg;
			bits               <= next_bits;
			div                <= next_div;
			busy               <= next_busy;
			serial_clk         <= next_sclk;
			receive_frame_sync <= next_fs;
			serial_data        <= next_sd;
			done               <= next_done;
		end
	end
endmodule // bls_serial_tx

// [rtl/bls_host.sv]
/*
 * boot loader host controller: holds a boot image written by software,
 * resets the device, driving the chosen select lines before release in
 * handshake mode and after it in the others, then feeds the image by the
 * two-wire handshake or the serial port, checking the stream layout.
 * assumes device pins are synchronous to clk and software uses the plain
 * register port (read data one cycle after the read strobe).
 */
`timescale 1ns/1ps
// Summary of operation
// - host makes serial bit clock and frame sync
// - serial words are sent msb first, lsb last
// - serial stream omits the leading memory width word
// - loader mode pin stays high through reset and whole load
// - handshake mode needs both select lines low before reset release
// - other modes may drive their select line after reset release
// - host drives data ready low only with a valid word
// - host returns data ready high after acknowledge goes low
// - memory stream starts with width and three strobe config words
// - each block starts with size, load address, strobe config word
// - internal memory blocks carry a zero strobe config word
// - a zero block size ends the stream
// - width word codes are 8h, 10h, 20h
// - strobe config low digit 0 io, 4 primary, 8 secondary
module bls_host
	import bls_pkg::*;
(
	input  wire logic         clk,
	input  wire logic         reset_n,
	input  wire bls_req_type  req,
	output logic [31:0]       rdata,
	input  wire logic         load_ack_out,
	input  wire logic         wait_pulse_out,
	output logic              dev_reset_n,
	output logic              loader_mode_pin,
	output logic              boot_select_line_a,
	output logic              boot_select_line_b,
	output logic              boot_select_line_c,
	output logic              boot_select_line_d,
	output logic              host_data_ready_in,
	output logic [31:0]       boot_data,
	output logic              serial_clk,
	output logic              receive_frame_sync,
	output logic              serial_data
);
	typedef enum {ST_IDLE, ST_RESET, ST_RELEASE, ST_HS_PRESENT, ST_HS_ACK,
		ST_HS_REL, ST_SER_SEND, ST_SER_WAIT, ST_MEM_RUN, ST_DONE}
		bls_state_type;
	typedef enum {PH_HDR, PH_SIZE, PH_ADDR, PH_CFG, PH_DATA, PH_END}
		bls_phase_type;

	logic [31:0] image [IMG_DEPTH];
	bls_state_type state, next_state;
	bls_phase_type phase, next_phase;
	logic [1:0]  mode, next_mode, base, next_base;
	logic [7:0]  cnt, next_cnt;
	logic [IMG_AW-1:0] idx, next_idx, wptr, next_wptr;
	logic [IMG_AW:0]   len, next_len;
	logic [2:0]  hcnt, next_hcnt;
	logic [24:0] remain, next_remain;
	logic        first, next_first;
	logic        err_width, next_err_width, err_cfg, next_err_cfg;
	logic        err_addr, next_err_addr, err_trunc, next_err_trunc;
	logic        done, next_done;
	logic [15:0] waits, next_waits;
	logic        wait_prev, next_wait_prev;
	logic [3:0]  sel, next_sel;
	logic        rst_o, next_rst_o, rdy, next_rdy;
	logic [31:0] bdata, next_bdata, next_rdata;
	logic        ser_start, next_ser_start, ser_done;
	logic        ser_clk_i, ser_fs_i, ser_sd_i;
	logic        accept;
	logic [31:0] cur;
	logic [3:0]  mem_sel;
	logic        last;

	assign cur = image[idx];

	bls_serial_tx u_serial (
		.clk                (clk),
		.reset_n            (reset_n),
		.start              (ser_start),
		.word               (cur),
		.serial_clk         (ser_clk_i),
		.receive_frame_sync (ser_fs_i),
		.serial_data        (ser_sd_i),
		.done               (ser_done)
	);

	// ********************
	// image store
	// ********************
	always_ff @(posedge clk) begin
		if (req.wr && req.addr == REG_IMG_DATA)
			image[wptr] <= req.wdata;
	end

	// ********************
	// sequencer and stream checker
	// ********************
	always_comb begin
		next_state = state;       next_phase = phase;
		next_mode = mode;         next_base = base;
		next_cnt = cnt;           next_idx = idx;
		next_wptr = wptr;         next_len = len;
		next_hcnt = hcnt;         next_remain = remain;
		next_first = first;       next_done = done;
		next_err_width = err_width;  next_err_cfg = err_cfg;
		next_err_addr = err_addr;    next_err_trunc = err_trunc;
		next_sel = sel;           next_rst_o = rst_o;
		next_rdy = rdy;           next_bdata = bdata;
		next_ser_start = 1'b0;
		next_wait_prev = wait_pulse_out;
		next_waits = waits;
		accept = 1'b0;
		last = 1'b0;
		case (base)
		BASE_A:  mem_sel = 4'b1110;
		BASE_B:  mem_sel = 4'b1101;
		default: mem_sel = 4'b1011;
		endcase
		if (wait_pulse_out && !wait_prev && state == ST_HS_ACK)
			next_waits = waits + 16'h1;
		if (req.wr) begin
			case (req.addr)
			REG_IMG_ADDR: next_wptr = req.wdata[IMG_AW-1:0];
			REG_IMG_DATA: next_wptr = wptr + 1'b1;
			REG_IMG_LEN:  next_len = req.wdata[IMG_AW:0];
			default: ;
			endcase
		end
		case (state)
		ST_IDLE: begin
			if (req.wr && req.addr == REG_CTRL && req.wdata[CTRL_START]
				&& req.wdata[CTRL_MODE_LSB+:2] != 2'h3
				&& req.wdata[CTRL_BASE_LSB+:2] != 2'h3) begin
				next_mode  = req.wdata[CTRL_MODE_LSB+:2];
				next_base  = req.wdata[CTRL_BASE_LSB+:2];
				next_state = ST_RESET;
				next_cnt   = DEV_RESET_CYC;
				next_rst_o = 1'b0;
				next_done  = 1'b0;
				next_waits = 16'h0;
				next_err_width = 1'b0;  next_err_cfg = 1'b0;
				next_err_addr = 1'b0;   next_err_trunc = 1'b0;
				next_phase = PH_HDR;
				next_first = 1'b1;
				next_sel   = 4'hf;
				if (req.wdata[CTRL_MODE_LSB+:2] == MODE_SERIAL) begin
					next_idx  = IMG_AW'(1);
					next_hcnt = HDR_WORDS_SER;
				end else begin
					next_idx  = '0;
					next_hcnt = HDR_WORDS_MEM;
				end
			end
		end
		ST_RESET: begin
			// handshake lines are set up before the device leaves reset
			if (mode == MODE_HSHAKE) begin
				case (base)
				BASE_A:  next_sel = 4'b0110;
				BASE_B:  next_sel = 4'b0101;
				default: next_sel = 4'b0011;
				endcase
			end
			if (cnt <= 8'h1) begin
				next_rst_o = 1'b1;
				next_cnt   = SEL_SETUP_CYC;
				next_state = ST_RELEASE;
			end else begin
				next_cnt = cnt - 8'h1;
			end
		end
		ST_RELEASE: begin
			if (cnt <= 8'h1) begin
				case (mode)
				MODE_SERIAL: begin
					next_sel   = 4'b0111;
					next_state = ST_SER_SEND;
				end
				MODE_HSHAKE: next_state = ST_HS_PRESENT;
				default: begin
					next_sel   = mem_sel;
					next_state = ST_MEM_RUN;
				end
				endcase
			end else begin
				next_cnt = cnt - 8'h1;
			end
		end
		ST_HS_PRESENT: begin
			next_bdata = cur;
			next_state = ST_HS_ACK;
		end
		ST_HS_ACK: begin
			next_rdy = 1'b0;
			if (!rdy && !load_ack_out) begin
				next_rdy   = 1'b1;
				accept     = 1'b1;
				next_state = ST_HS_REL;
			end
		end
		ST_HS_REL: begin
			if (load_ack_out)
				next_state = (phase == PH_END || done) ? ST_DONE
					: ST_HS_PRESENT;
		end
		ST_SER_SEND: begin
			next_ser_start = 1'b1;
			next_state     = ST_SER_WAIT;
		end
		ST_SER_WAIT: begin
			if (ser_done) begin
				accept     = 1'b1;
				next_state = ST_SER_SEND;
			end
		end
		ST_MEM_RUN: begin
			if (req.wr && req.addr == REG_CTRL && req.wdata[CTRL_FINISH]) begin
				next_done  = 1'b1;
				next_state = ST_DONE;
			end
		end
		ST_DONE: begin
			next_sel   = 4'hf;
			next_state = ST_IDLE;
		end
		default: next_state = ST_IDLE;
		endcase
		if (accept) begin
			next_first = 1'b0;
			last = ({1'b0, idx} + 1'b1) >= len;
			case (phase)
			PH_HDR: begin
				if (first && mode != MODE_SERIAL && cur != WIDTH_8
					&& cur != WIDTH_16 && cur != WIDTH_32)
					next_err_width = 1'b1;
				next_hcnt = hcnt - 3'h1;
				if (hcnt == 3'h1)
					next_phase = PH_SIZE;
			end
			PH_SIZE: begin
				next_remain = cur[24:0];
				next_phase  = (cur == 32'h0) ? PH_END : PH_ADDR;
			end
			PH_ADDR: begin
				if (cur[23:0] < MIN_LOAD_ADDR)
					next_err_addr = 1'b1;
				next_phase = PH_CFG;
			end
			PH_CFG: begin
				if (cur != 32'h0 && cur[3:0] != STRB_IO
					&& cur[3:0] != STRB_PRI && cur[3:0] != STRB_SEC)
					next_err_cfg = 1'b1;
				next_phase = (cur[24:0] == 25'h0 && remain == 25'h0)
					? PH_SIZE : PH_DATA;
			end
			PH_DATA: begin
				next_remain = remain - 25'h1;
				if (remain == 25'h1)
					next_phase = PH_SIZE;
			end
			default: ;
			endcase
			next_idx = idx + 1'b1;
			if (phase == PH_SIZE && cur == 32'h0) begin
				next_done = 1'b1;
				if (mode == MODE_SERIAL)
					next_state = ST_DONE;
			end else if (last) begin
				next_err_trunc = 1'b1;
				next_done      = 1'b1;
				if (mode == MODE_SERIAL)
					next_state = ST_DONE;
			end
		end
	end

	// ********************
	// register read
	// ********************
	always_comb begin
		next_rdata = 32'h00000000;
		if (req.rd) begin
			case (req.addr)
			REG_CTRL:     next_rdata = {27'h0, base, mode, 1'b0};
			REG_STATUS:   next_rdata = {22'h0, err_trunc, err_cfg, err_addr,
				err_width, done, (state != ST_IDLE), 4'(phase)};
			REG_IMG_ADDR: next_rdata = {24'h0, wptr};
			REG_IMG_LEN:  next_rdata = {23'h0, len};
			REG_WAITS:    next_rdata = {16'h0, waits};
			REG_BASE: begin
				case (base)
				BASE_A:  next_rdata = {8'h0, BOOT_ADDR_A};
				BASE_B:  next_rdata = {8'h0, BOOT_ADDR_B};
				default: next_rdata = {8'h0, BOOT_ADDR_C};
				endcase
			end
			default: next_rdata = 32'h00000000;
			endcase
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			state <= ST_IDLE;    phase <= PH_HDR;
			mode <= 2'h0;        base <= 2'h0;
			cnt <= 8'h00;        idx <= '0;
			wptr <= '0;          len <= '0;
			hcnt <= 3'h0;        remain <= 25'h0;
			first <= 1'b0;       done <= 1'b0;
			err_width <= 1'b0;   err_cfg <= 1'b0;
			err_addr <= 1'b0;    err_trunc <= 1'b0;
			sel <= 4'hf;         rst_o <= 1'b1;
			rdy <= 1'b1;         bdata <= 32'h00000000;
			ser_start <= 1'b0;   wait_prev <= 1'b0;
			waits <= 16'h0000;   rdata <= 32'h00000000;
			dev_reset_n <= 1'b1;
			loader_mode_pin <= 1'b1;
			boot_select_line_a <= 1'b1;
			boot_select_line_b <= 1'b1;
			boot_select_line_c <= 1'b1;
			boot_select_line_d <= 1'b1;
			host_data_ready_in <= 1'b1;
			boot_data <= 32'h00000000;
			serial_clk <= 1'b0;
			receive_frame_sync <= 1'b0;
			serial_data <= 1'b0;
		end else begin
			state <= next_state;  phase <= next_phase;
			mode <= next_mode;    base <= next_base;
			cnt <= next_cnt;      idx <= next_idx;
			wptr <= next_wptr;    len <= next_len;
			hcnt <= next_hcnt;    remain <= next_remain;
			first <= next_first;  done <= next_done;
			err_width <= next_err_width;  err_cfg <= next_err_cfg;
			err_addr <= next_err_addr;    err_trunc <= next_err_trunc;
			sel <= next_sel;      rst_o <= next_rst_o;
			rdy <= next_rdy;      bdata <= next_bdata;
			ser_start <= next_ser_start;  wait_prev <= next_wait_prev;
			waits <= next_waits;  rdata <= next_rdata;
			dev_reset_n <= next_rst_o;
			loader_mode_pin <= 1'b1;
			boot_select_line_a <= next_sel[0];
			boot_select_line_b <= next_sel[1];
			boot_select_line_c <= next_sel[2];
			boot_select_line_d <= next_sel[3];
			host_data_ready_in <= next_rdy;
			boot_data <= next_bdata;
			serial_clk <= ser_clk_i;
			receive_frame_sync <= ser_fs_i;
			serial_data <= ser_sd_i;
		end
	end
endmodule // bls_host

// [dv/bls_dev_model.sv]
/*
 * behavioural device for the boot loader host: mode pick, handshake
 * answers and serial word capture into the queue words.
 * assumes host pins are synchronous to clk; ack_wait slows the answer.
 */
`timescale 1ns/1ps
module bls_dev_model
	import bls_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        dev_reset_n,
	input  wire logic        boot_select_line_a,
	input  wire logic        boot_select_line_b,
	input  wire logic        boot_select_line_c,
	input  wire logic        boot_select_line_d,
	input  wire logic        host_data_ready_in,
	input  wire logic [31:0] boot_data,
	input  wire logic        serial_clk,
	input  wire logic        receive_frame_sync,
	input  wire logic        serial_data,
	input  wire logic [3:0]  ack_wait,
	output logic             load_ack_out,
	output logic             wait_pulse_out
);
	// ********************
	// mode, handshake, serial
	// ********************
	logic [1:0]  mode;
	logic [1:0]  base;
	logic [31:0] shreg;
	logic        sclk_q;
	int          nbit;
	int          dly;
	logic [31:0] words[$];
	logic [3:0]  sel;
	logic [23:0] pc;
	logic [31:0] strb_cfg[3];
	int          hdr;
	localparam logic [23:0] LOADER_ENTRY = 24'h000045;

	assign hdr = (mode == 2'h1) ? 0 : 1;

	// loader entry, then header strobe values and first block address
	always @(posedge clk or negedge dev_reset_n) begin
		if (!dev_reset_n)
			pc <= LOADER_ENTRY;
		else if (words.size() > 5) begin
			strb_cfg <= '{words[hdr], words[hdr + 1],
				words[hdr + 2]};
			pc <= words[hdr + 4][23:0];
		end
	end

	assign sel = {boot_select_line_d, boot_select_line_c,
		boot_select_line_b, boot_select_line_a};

	// mode 0 none, 1 serial, 2 handshake, 3 memory; polls until valid
	always @(posedge clk or negedge dev_reset_n) begin
		if (!dev_reset_n) begin
			mode <= 2'h0;
			base <= 2'h0;
		end else if (mode == 2'h0) begin
			case (sel)
				4'b1110: begin mode <= 2'h3; base <= 2'h0; end
				4'b1101: begin mode <= 2'h3; base <= 2'h1; end
				4'b1011: begin mode <= 2'h3; base <= 2'h2; end
				4'b0111: mode <= 2'h1;
				4'b0110: begin mode <= 2'h2; base <= 2'h0; end
				4'b0101: begin mode <= 2'h2; base <= 2'h1; end
				4'b0011: begin mode <= 2'h2; base <= 2'h2; end
				default: mode <= 2'h0;
			endcase
		end
	end

	always @(posedge clk or negedge dev_reset_n) begin
		if (!dev_reset_n) begin
			load_ack_out   <= 1'b1;
			wait_pulse_out <= 1'b0;
			dly            <= 0;
		end else if (mode == 2'h2) begin
			if (load_ack_out) begin
				wait_pulse_out <= host_data_ready_in & ~wait_pulse_out;
				if (!host_data_ready_in && dly < int'(ack_wait))
					dly <= dly + 1;
				else if (!host_data_ready_in) begin
					words.push_back(boot_data);
					load_ack_out <= 1'b0;
					dly          <= 0;
				end
			end else if (host_data_ready_in)
				load_ack_out <= 1'b1;
		end
	end

	// 32-bit frames sampled on rising bit clock, msb first
	always @(posedge clk) begin
		sclk_q <= serial_clk;
		if (serial_clk && !sclk_q) begin
			shreg <= {shreg[30:0], serial_data};
			nbit  <= receive_frame_sync ? 1 : nbit + 1;
			if (!receive_frame_sync && nbit == 31)
				words.push_back({shreg[30:0], serial_data});
		end
	end
endmodule // bls_dev_model

// [dv/bls_host_sva.sv]
/*
 * checker for the boot loader host pins, bound into bls_host.
 * assumes only the ports of bls_host.
 */
`timescale 1ns/1ps
module bls_host_sva
	import bls_pkg::*;
(
	input wire logic        clk,
	input wire logic        reset_n,
	input wire logic        load_ack_out,
	input wire logic        dev_reset_n,
	input wire logic        loader_mode_pin,
	input wire logic        boot_select_line_a,
	input wire logic        boot_select_line_b,
	input wire logic        boot_select_line_c,
	input wire logic        boot_select_line_d,
	input wire logic        host_data_ready_in,
	input wire logic [31:0] boot_data,
	input wire logic        serial_clk,
	input wire logic        receive_frame_sync,
	input wire logic        serial_data
);
	// ********************
	// properties
	// ********************
	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);
	logic abc;
	assign abc = boot_select_line_a & boot_select_line_b & boot_select_line_c;

	property p_mode; loader_mode_pin; endproperty
	property p_hold; !host_data_ready_in && !$past(host_data_ready_in)
		|-> $stable(boot_data); endproperty
	property p_fall; $fell(host_data_ready_in) |-> $past(load_ack_out);
	endproperty
	property p_keep; !host_data_ready_in && load_ack_out
		|=> !host_data_ready_in; endproperty
	property p_rel; $fell(load_ack_out) |-> ##[0:4] host_data_ready_in;
	endproperty
	property p_hs_sel; $rose(dev_reset_n) && !boot_select_line_d |-> !abc;
	endproperty
	property p_one_sel; $rose(dev_reset_n) && boot_select_line_d |-> abc;
	endproperty
	property p_bit; $rose(serial_clk) |=> serial_clk && $stable(serial_data);
	endproperty
	property p_sclk; serial_clk || receive_frame_sync |-> !boot_select_line_d;
	endproperty

	a_mode: assert property (p_mode) else $error("mode pin low");
	a_hold: assert property (p_hold) else $error("data moved");
	a_fall: assert property (p_fall) else $error("ready early");
	a_keep: assert property (p_keep) else $error("ready left");
	a_rel: assert property (p_rel) else $error("ready stuck");
	a_hs_sel: assert property (p_hs_sel) else $error("hs sel");
	a_one_sel: assert property (p_one_sel) else $error("sel early");
	a_bit: assert property (p_bit) else $error("bit moved");
	a_sclk: assert property (p_sclk) else $error("serial idle");

	c_ack: cover property ($fell(load_ack_out));
	c_frame: cover property ($rose(receive_frame_sync));
	c_hs: cover property ($rose(dev_reset_n) && !boot_select_line_d);
endmodule // bls_host_sva

bind bls_host bls_host_sva sva_i (.clk(clk), .reset_n(reset_n),
	.load_ack_out(load_ack_out), .dev_reset_n(dev_reset_n),
	.loader_mode_pin(loader_mode_pin),
	.boot_select_line_a(boot_select_line_a),
	.boot_select_line_b(boot_select_line_b),
	.boot_select_line_c(boot_select_line_c),
	.boot_select_line_d(boot_select_line_d),
	.host_data_ready_in(host_data_ready_in), .boot_data(boot_data),
	.serial_clk(serial_clk), .receive_frame_sync(receive_frame_sync),
	.serial_data(serial_data));

// [dv/testbench.sv]
/*
 * testbench of bls_host with the device model on its pins.
 * assumes the plain register port of bls_host.
 */
`timescale 1ns/1ps
module testbench;
	import bls_pkg::*;
	// ********************
	// bench
	// ********************
	logic        clk = 1'b0;
	logic        reset_n = 1'b0;
	bls_req_type req = '0;
	logic [31:0] rdata, boot_data, v, img[10];
	logic [3:0]  ack_wait = 4'h0;
	logic        ack, wpo, drst_n, lmp, sa, sb, sc, sd, rdy, sck, fs, sdo;
	int          error_cnt = 0, compares = 0, cycles = 0;
	logic [23:0] bases[3] = '{BOOT_ADDR_A, BOOT_ADDR_B, BOOT_ADDR_C};
	logic [31:0] widths[3] = '{WIDTH_8, WIDTH_16, WIDTH_32};
	logic [3:0]  codes[3] = '{STRB_IO, STRB_PRI, STRB_SEC};

	bls_host bls_host_i (.clk(clk), .reset_n(reset_n), .req(req),
		.rdata(rdata), .load_ack_out(ack), .wait_pulse_out(wpo),
		.dev_reset_n(drst_n), .loader_mode_pin(lmp),
		.boot_select_line_a(sa), .boot_select_line_b(sb),
		.boot_select_line_c(sc), .boot_select_line_d(sd),
		.host_data_ready_in(rdy), .boot_data(boot_data),
		.serial_clk(sck), .receive_frame_sync(fs), .serial_data(sdo));
	bls_dev_model dev_i (.clk(clk), .dev_reset_n(drst_n),
		.boot_select_line_a(sa), .boot_select_line_b(sb),
		.boot_select_line_c(sc), .boot_select_line_d(sd),
		.host_data_ready_in(rdy), .boot_data(boot_data),
		.serial_clk(sck), .receive_frame_sync(fs), .serial_data(sdo),
		.ack_wait(ack_wait), .load_ack_out(ack), .wait_pulse_out(wpo));

	always #50 clk = ~clk;
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 60000) begin
			error_cnt++;
			stop_test;
		end
	end

	task automatic stop_test;
		$display("compares %0d error_cnt %0d", compares, error_cnt);
		if (error_cnt == 0 && compares > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			error_cnt++;
			$display("BAD %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge clk);
		req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge clk);
		req <= '0;
	endtask
	task automatic rd(input logic [3:0] a, output logic [31:0] d);
		@(posedge clk);
		req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
		@(posedge clk);
		req <= '0;
		@(negedge clk);
		d = rdata;
	endtask
	task automatic make_img(input logic [31:0] w, input logic [31:0] cfg);
		img = '{w, 32'h1, 32'h2, 32'h3, 32'h2, 32'h00809c00, cfg,
			32'hcafe0001, 32'h5a5a0002, 32'h0};
	endtask
	// load image, start, poll until not busy
	task automatic run(input logic [1:0] m, input logic [1:0] b, input int n);
		int k;
		dev_i.words.delete();
		wr(REG_IMG_ADDR, 32'h0);
		for (int i = 0; i < n; i++)
			wr(REG_IMG_DATA, img[i]);
		wr(REG_IMG_LEN, 32'(n));
		wr(REG_CTRL, {27'h0, b, m, 1'b1});
		k = 0;
		do begin
			rd(REG_STATUS, v);
			k++;
		end while (v[4] !== 1'b0 && k < 4000);
	endtask

	initial begin
		repeat (20) @(posedge clk);
		reset_n <= 1'b1;
		// handshake loads from each base, every width and strobe code
		for (int i = 0; i < 3; i++) begin
			make_img(widths[i], {24'h000010, 4'h6, codes[i]});
			ack_wait <= 4'(3 * i);
			run(MODE_HSHAKE, 2'(i), 10);
			chk({22'h0, v[9:0] & 10'h3e0}, 32'h20);
			chk({30'h0, dev_i.mode}, 32'h2);
			chk({30'h0, dev_i.base}, 32'(i));
			rd(REG_BASE, v);
			chk(v, {8'h0, bases[i]});
			rd(REG_WAITS, v);
			chk({31'h0, v !== 32'h0}, 32'h1);
			chk(32'(dev_i.words.size()), 32'd10);
			for (int j = 0; j < 10 && j < dev_i.words.size(); j++)
				chk(dev_i.words[j], img[j]);
			chk({8'h0, dev_i.pc}, 32'h00809c00);
			chk(dev_i.strb_cfg[0], 32'h1);
			rd(REG_CTRL, v);
			chk(v, {27'h0, 2'(i), MODE_HSHAKE, 1'b0});
			rd(REG_IMG_LEN, v);
			chk(v, 32'd10);
		end
		// serial load skips the width word
		make_img(WIDTH_32, 32'h0);
		run(MODE_SERIAL, BASE_A, 10);
		chk({30'h0, dev_i.mode}, 32'h1);
		chk(32'(dev_i.words.size()), 32'd9);
		for (int j = 0; j < 9 && j < dev_i.words.size(); j++)
			chk(dev_i.words[j], img[j + 1]);
		chk(dev_i.strb_cfg[2], 32'h3);
		chk({8'h0, dev_i.pc}, 32'h00809c00);
		// faults: width, low address, strobe code, image run out
		for (int k = 0; k < 4; k++) begin
			make_img(WIDTH_32, 32'h0);
			if (k == 0)
				img[0] = 32'h0000000c;
			if (k == 1)
				img[5] = 32'h00000800;
			if (k == 2)
				img[6] = 32'h00000063;
			run(MODE_HSHAKE, BASE_A, k == 3 ? 9 : 10);
			chk({28'h0, v[9:6]}, 32'(1 << k));
		end
		// memory mode without handshake, ended by finish
		make_img(WIDTH_32, 32'h0);
		dev_i.words.delete();
		wr(REG_CTRL, {27'h0, BASE_B, MODE_MEMORY, 1'b1});
		repeat (40) @(posedge clk);
		chk({30'h0, dev_i.mode}, 32'h3);
		chk({30'h0, dev_i.base}, 32'h1);
		wr(REG_CTRL, 32'h20);
		repeat (4) @(posedge clk);
		rd(REG_STATUS, v);
		chk({30'h0, v[5:4]}, 32'h2);
		chk({8'h0, dev_i.pc}, 32'h00000045);
		stop_test;
	end
endmodule // testbench
